//--- core/capw_map.svh
// Offsets, field positions and reset values of the counter array.
// Assumes a word-indexed register bus; each index holds one 8-bit register.
`ifndef CAPW_MAP_SVH
`define CAPW_MAP_SVH

// ==========================================================
// Array size
`define CAPW_NUM_MODULES     5
`define CAPW_WDT_MODULE      4

// ==========================================================
// Register indices
`define CAPW_OFS_CTRL        8'hD8
`define CAPW_OFS_CFG         8'hD9
`define CAPW_OFS_MODE0       8'hDA
`define CAPW_OFS_CNT_LOW     8'hE9
`define CAPW_OFS_CMPL0       8'hEA
`define CAPW_OFS_CNT_HIGH    8'hF9
`define CAPW_OFS_CMPH0       8'hFA

// ==========================================================
// Fields
`define CAPW_CTRL_OVF_BIT    7
`define CAPW_CTRL_RUN_BIT    6
`define CAPW_CFG_WDT_ARM_BIT 6
`define CAPW_CFG_OVF_IE_BIT  0
`define CAPW_CFG_MASK        8'hC7
`define CAPW_MODE_MASK       8'h7F

// ==========================================================
// Values
`define CAPW_BYTE_RESET      8'h00
`define CAPW_BYTE_MAX        8'hFF
`define CAPW_PIN_IDLE        1'b1
`define CAPW_WORD_RESET      32'h0000_0000

`endif

//--- core/capw_pkg.sv
// Types shared by the counter array modules.
// Assumes capw_map.svh supplies the numeric constants.
package capw_pkg;

  // ==========================================================
  // Module mode byte, msb first
  typedef struct packed {
    logic rsvd;
    logic compare_enable;
    logic capture_pos;
    logic capture_neg;
    logic match_flag_enable;
    logic toggle_on_match;
    logic pulse_width;
    logic module_irq_enable;
  } capw_mode_type;

  // ==========================================================
  // Register write strobes with their byte
  typedef struct packed {
    logic       mode_wr;
    logic       low_wr;
    logic       high_wr;
    logic [7:0] data;
  } capw_wr_type;

  // ==========================================================
  // Shared counter as seen by every module
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic       tick;
  } capw_count_type;

  // ==========================================================
  // Module state returned to the top
  typedef struct packed {
    capw_mode_type mode;
    logic [7:0]    cmp_low;
    logic [7:0]    cmp_high;
    logic          match;
    logic          pin;
  } capw_stat_type;

endpackage

//--- core/capw_counter.sv
// Shared 16-bit time base of the counter array.
// Assumes run and writes come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "capw_map.svh"

module capw_counter (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Control; low_wr/high_wr load the count bytes
  input  wire logic                     run,
  input  wire capw_pkg::capw_wr_type    wr,
  // Count and wrap of the full 16 bits
  output var  capw_pkg::capw_count_type count,
  output logic                          overflow
);

  logic [7:0] low_r;
  logic [7:0] low_nxt;
  logic [7:0] high_r;
  logic [7:0] high_nxt;

  always_comb begin
    low_nxt  = low_r;
    high_nxt = high_r;
    if (run) begin
      low_nxt = low_r + 8'h01;
      if (low_r == `CAPW_BYTE_MAX) begin
        high_nxt = high_r + 8'h01;
      end
    end
    // Software load beats counting
    if (wr.low_wr) begin
      low_nxt = wr.data;
    end
    if (wr.high_wr) begin
      high_nxt = wr.data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_r  <= `CAPW_BYTE_RESET;
      high_r <= `CAPW_BYTE_RESET;
    end else begin
      low_r  <= low_nxt;
      high_r <= high_nxt;
    end
  end

  assign count.low  = low_r;
  assign count.high = high_r;
  assign count.tick = run;
  assign overflow   = run && (low_r == `CAPW_BYTE_MAX) && (high_r == `CAPW_BYTE_MAX);

endmodule
`default_nettype wire

//--- core/capw_module.sv
// One compare module: mode byte, compare bytes, match and output pin.
// Assumes the shared count and write strobes arrive on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "capw_map.svh"

module capw_module (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Register writes and shared count
  input  wire capw_pkg::capw_wr_type    wr,
  input  wire capw_pkg::capw_count_type count,
  // State, match pulse and pin
  output var  capw_pkg::capw_stat_type  stat
);

  capw_pkg::capw_mode_type mode_r;
  capw_pkg::capw_mode_type mode_nxt;
  logic [7:0]              low_r;
  logic [7:0]              low_nxt;
  logic [7:0]              high_r;
  logic [7:0]              high_nxt;
  logic                    pin_r;
  logic                    pin_nxt;
  logic                    match;
  logic                    pwm_on;
  logic                    wrap;

  // Compare only on a count step, so a stopped counter cannot re-fire
  assign match  = count.tick && mode_r.compare_enable && mode_r.match_flag_enable &&
                  ({count.high, count.low} == {high_r, low_r});
  assign pwm_on = mode_r.pulse_width && mode_r.compare_enable;
  assign wrap   = count.tick && (count.low == `CAPW_BYTE_MAX);

  always_comb begin
    mode_nxt = mode_r;
    low_nxt  = low_r;
    high_nxt = high_r;
    pin_nxt  = pin_r;
    if (wr.mode_wr) begin
      mode_nxt = capw_pkg::capw_mode_type'(wr.data & `CAPW_MODE_MASK);
    end
    if (wr.low_wr) begin
      low_nxt                 = wr.data;
      mode_nxt.compare_enable = 1'b0;
    end
    if (wr.high_wr) begin
      high_nxt                = wr.data;
      mode_nxt.compare_enable = 1'b1;
    end
    if (pwm_on) begin
      // Duty byte swapped only at the wrap, so a period is never cut short
      if (wrap) begin
        low_nxt = high_r;
      end
      pin_nxt = (count.low >= low_r);
    end else if (match && mode_r.toggle_on_match) begin
      pin_nxt = ~pin_r;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r <= capw_pkg::capw_mode_type'(`CAPW_BYTE_RESET);
      low_r  <= `CAPW_BYTE_RESET;
      high_r <= `CAPW_BYTE_RESET;
      pin_r  <= `CAPW_PIN_IDLE;
    end else begin
      mode_r <= mode_nxt;
      low_r  <= low_nxt;
      high_r <= high_nxt;
      pin_r  <= pin_nxt;
    end
  end

  assign stat.mode     = mode_r;
  assign stat.cmp_low  = low_r;
  assign stat.cmp_high = high_r;
  assign stat.match    = match;
  assign stat.pin      = pin_r;

endmodule
`default_nettype wire

//--- core/capw_top.sv
// Compare side of a five-module counter array with watchdog on module 4.
// Assumes an Avalon-MM master on clk; address is the word index of a register.
//
// Overview of operation
// - Compare enabled modules against counter every count (here a match also needs the match flag enable bit)
// - Interrupt only when flag and enable set
// - High compare byte write sets compare enable
// - Low compare byte write clears compare enable
// - Compare enable also reachable through mode byte
// - Toggle mode inverts pin on each match
// - Pulse mode needs pulse and compare bits
// - All pulse outputs share one counter frequency
// - Duty set per module by low byte
// - Pin low below duty byte, else high
// - Counter low wrap reloads duty from high
// - Watchdog only on module 4, else normal
// - Watchdog compares preloaded value like others
// - Watchdog match raises internal reset only
// - Clearing watchdog arm prevents the reset
// - Event flag sticky until software clears
// - Module interrupt enable gates its flag
`timescale 1ns/1ps
`default_nettype none
`include "capw_map.svh"

module capw_top (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Avalon-MM slave
  input  wire logic [7:0]                    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  output logic      [31:0]                   avs_readdata,
  output logic                               avs_waitrequest,
  // Module outputs
  output logic      [`CAPW_NUM_MODULES-1:0]  module_output_pin,
  // Events to the core
  output logic                               irq_request,
  output logic                               internal_reset_req
);

  // ==========================================================
  // Register index decode
  function automatic logic at_slot(input logic [7:0] addr, input logic [7:0] base, input int idx);
    return addr == (base + idx[7:0]);
  endfunction

  // ==========================================================
  // Declarations
  localparam int N = `CAPW_NUM_MODULES;

  logic                     ack_r;
  logic                     ack_nxt;
  logic [31:0]              rdata_r;
  logic [31:0]              rdata_nxt;
  logic                     wr_go;
  logic                     rd_go;
  logic [7:0]               rd_byte;
  logic [7:0]               wbyte;

  logic [N-1:0]             flags_r;
  logic [N-1:0]             flags_nxt;
  logic                     ovf_r;
  logic                     ovf_nxt;
  logic                     run_r;
  logic                     run_nxt;
  logic [7:0]               cfg_r;
  logic [7:0]               cfg_nxt;
  logic                     irq_r;
  logic                     irq_nxt;
  logic                     wdt_r;
  logic                     wdt_nxt;

  capw_pkg::capw_wr_type    cnt_wr;
  capw_pkg::capw_count_type count;
  logic                     overflow;
  capw_pkg::capw_wr_type    mod_wr [N];
  capw_pkg::capw_stat_type  stat   [N];
  logic [N-1:0]             match_vec;
  logic [N-1:0]             irq_en_vec;

  // ==========================================================
  // Bus handshake
  // One wait state: request is seen, then answered with registered data
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign wr_go           = avs_write && ack_r;
  assign rd_go           = avs_read && !ack_r;
  assign wbyte           = avs_writedata[7:0];

  always_comb begin
    ack_nxt   = (avs_read || avs_write) && !ack_r;
    rdata_nxt = rdata_r;
    if (rd_go) begin
      rdata_nxt = {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_r   <= 1'b0;
      rdata_r <= `CAPW_WORD_RESET;
    end else begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_readdata = rdata_r;

  // ==========================================================
  // Write strobes
  always_comb begin
    cnt_wr.mode_wr = 1'b0;
    cnt_wr.low_wr  = wr_go && (avs_address == `CAPW_OFS_CNT_LOW);
    cnt_wr.high_wr = wr_go && (avs_address == `CAPW_OFS_CNT_HIGH);
    cnt_wr.data    = wbyte;
    for (int i = 0; i < N; i++) begin
      mod_wr[i].mode_wr = wr_go && at_slot(avs_address, `CAPW_OFS_MODE0, i);
      mod_wr[i].low_wr  = wr_go && at_slot(avs_address, `CAPW_OFS_CMPL0, i);
      mod_wr[i].high_wr = wr_go && at_slot(avs_address, `CAPW_OFS_CMPH0, i);
      mod_wr[i].data    = wbyte;
    end
  end

  // ==========================================================
  // Shared counter and compare modules
  capw_counter u_counter (
    .clk      (clk),
    .rst      (rst),
    .run      (run_r),
    .wr       (cnt_wr),
    .count    (count),
    .overflow (overflow)
  );

  for (genvar g = 0; g < N; g++) begin : g_mod
    capw_module u_module (
      .clk   (clk),
      .rst   (rst),
      .wr    (mod_wr[g]),
      .count (count),
      .stat  (stat[g])
    );
    assign match_vec[g]         = stat[g].match;
    assign irq_en_vec[g]        = stat[g].mode.module_irq_enable;
    assign module_output_pin[g] = stat[g].pin;
  end

  // ==========================================================
  // Control, status and configuration
  always_comb begin
    flags_nxt = flags_r;
    ovf_nxt   = ovf_r;
    run_nxt   = run_r;
    cfg_nxt   = cfg_r;
    if (wr_go && (avs_address == `CAPW_OFS_CTRL)) begin
      flags_nxt = wbyte[N-1:0];
      ovf_nxt   = wbyte[`CAPW_CTRL_OVF_BIT];
      run_nxt   = wbyte[`CAPW_CTRL_RUN_BIT];
    end
    if (wr_go && (avs_address == `CAPW_OFS_CFG)) begin
      cfg_nxt = wbyte & `CAPW_CFG_MASK;
    end
    // Hardware set wins over a software clear in the same cycle
    flags_nxt = flags_nxt | match_vec;
    ovf_nxt   = ovf_nxt | overflow;
    irq_nxt   = (|(flags_nxt & irq_en_vec)) ||
                (ovf_nxt && cfg_nxt[`CAPW_CFG_OVF_IE_BIT]);
  end

  // ==========================================================
  // Watchdog on module 4
  // Module 4 still flags and toggles as usual; arming only adds the reset
  always_comb begin
    wdt_nxt = match_vec[`CAPW_WDT_MODULE] && cfg_r[`CAPW_CFG_WDT_ARM_BIT];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_r <= '0;
      ovf_r   <= 1'b0;
      run_r   <= 1'b0;
      cfg_r   <= `CAPW_BYTE_RESET;
      irq_r   <= 1'b0;
      wdt_r   <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      ovf_r   <= ovf_nxt;
      run_r   <= run_nxt;
      cfg_r   <= cfg_nxt;
      irq_r   <= irq_nxt;
      wdt_r   <= wdt_nxt;
    end
  end

  assign irq_request        = irq_r;
  // Internal only; the external reset pin is never driven
  assign internal_reset_req = wdt_r;

  // ==========================================================
  // Read mux
  always_comb begin
    rd_byte = `CAPW_BYTE_RESET;
    if (avs_address == `CAPW_OFS_CTRL) begin
      rd_byte                     = {ovf_r, run_r, 1'b0, flags_r};
    end else if (avs_address == `CAPW_OFS_CFG) begin
      rd_byte = cfg_r;
    end else if (avs_address == `CAPW_OFS_CNT_LOW) begin
      rd_byte = count.low;
    end else if (avs_address == `CAPW_OFS_CNT_HIGH) begin
      rd_byte = count.high;
    end
    for (int i = 0; i < N; i++) begin
      if (at_slot(avs_address, `CAPW_OFS_MODE0, i)) begin
        rd_byte = stat[i].mode;
      end
      if (at_slot(avs_address, `CAPW_OFS_CMPL0, i)) begin
        rd_byte = stat[i].cmp_low;
      end
      if (at_slot(avs_address, `CAPW_OFS_CMPH0, i)) begin
        rd_byte = stat[i].cmp_high;
      end
    end
  end

endmodule
`default_nettype wire

//--- tb/capw_top_sva.sv
// Port checker for the counter array top.
// Assumes a bind to capw_top on its own clk and rst.
`timescale 1ns/1ps
`default_nettype none

module capw_top_sva (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register bus
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Outputs
  input wire logic [4:0]  module_output_pin,
  input wire logic        irq_request,
  input wire logic        internal_reset_req
);
  // ==========
  // Watchdog arm as last written
  logic arm_r;
  logic arm_nxt;
  always_comb begin
    arm_nxt = arm_r;
    if (avs_write && !avs_waitrequest && avs_address == 8'hD9) arm_nxt = avs_writedata[6];
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) arm_r <= 1'b0;
    else arm_r <= arm_nxt;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ==========
  // Assertions
  one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  first_wait_a: assert property ($rose(avs_read) || $rose(avs_write) |-> avs_waitrequest)
    else $error("request answered without wait cycle");
  idle_nowait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high while idle");
  upper_zero_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address < 8'hD8 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  mode_msb_a: assert property (avs_read && !avs_waitrequest && avs_address inside {[8'hDA:8'hDE]} |-> !avs_readdata[7])
    else $error("mode byte msb reads one");
  wdt_pulse_a: assert property (internal_reset_req |=> !internal_reset_req)
    else $error("internal reset longer than one cycle");
  wdt_arm_a: assert property (internal_reset_req |-> arm_r || $past(arm_r))
    else $error("internal reset while watchdog disarmed");
  reset_idle_a: assert property (disable iff (1'b0) rst |-> module_output_pin == 5'h1F && !irq_request)
    else $error("outputs not idle in reset");

  cover property (internal_reset_req);
  cover property ($fell(module_output_pin[2]));
  cover property ($rose(irq_request));
endmodule

`default_nettype wire

//--- tb/capw_top_test.sv
// Self-checking bench for the counter array top.
// Assumes the design files and the port checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module capw_top_test;
  logic        clk;
  logic        rst;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [4:0]  module_output_pin;
  logic        irq_request;
  logic        internal_reset_req;
  logic [7:0]  exp_q[$];
  logic [7:0]  adr_q[$];
  logic [31:0] seed;
  logic        meas;
  int          errors;
  int          cmp_count;
  int          pulses;
  int          hi0;
  int          hi3;

  capw_top uut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .module_output_pin(module_output_pin), .irq_request(irq_request), .internal_reset_req(internal_reset_req));

  // ==========
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // Request held until the edge that sees waitrequest low
  task automatic bus(input logic r, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    avs_address   <= a;
    avs_read      <= r;
    avs_write     <= !r;
    avs_writedata <= {24'h000000, d};
    @(posedge clk);
    for (n = 0; n < 20 && avs_waitrequest !== 1'b0; n++) @(posedge clk);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b0, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    adr_q.push_back(a);
    exp_q.push_back(e);
    bus(1'b1, a, 8'h00);
  endtask

  task automatic finish_test;
    if (exp_q.size() != 0) errors++;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ==========
  // Read monitor and counters
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      chk($sformatf("reg %h", adr_q.pop_front()), {24'h000000, exp_q.pop_front()}, avs_readdata);
    if (internal_reset_req === 1'b1) pulses++;
    if (meas && module_output_pin[0] === 1'b1) hi0++;
    if (meas && module_output_pin[3] === 1'b1) hi3++;
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200us;
    errors++;
    finish_test();
  end

  // ==========
  // Scenarios
  initial begin
    logic [7:0] i;
    logic [7:0] v;
    rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    meas = 1'b0;
    seed = 32'h4A26;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 5; i++) begin
      rd(8'hDA + i, 8'h00);
      rd(8'hEA + i, 8'h00);
      rd(8'hFA + i, 8'h00);
    end
    rd(8'hD8, 8'h00);
    rd(8'hE9, 8'h00);
    rd(8'hF9, 8'h00);
    chk("pins", 5'h1F, module_output_pin);
    wr(8'h00, 8'h5A);
    rd(8'h00, 8'h00);
    wr(8'hD9, 8'hFF);
    rd(8'hD9, 8'hC7);
    wr(8'hD9, 8'h00);
    $display("test reset done");
    for (i = 0; i < 5; i++) begin
      v = seed[7:0] | 8'h01;
      seed = lfsr(seed);
      wr(8'hDA + i, 8'h08);
      wr(8'hFA + i, v);
      rd(8'hDA + i, 8'h48);
      wr(8'hEA + i, ~v);
      rd(8'hDA + i, 8'h08);
      wr(8'hDA + i, 8'h48);
      rd(8'hDA + i, 8'h48);
      rd(8'hEA + i, ~v);
      rd(8'hFA + i, v);
      wr(8'hDA + i, 8'h00);
    end
    $display("test compare enable done");
    // Match at 1305 needs the low byte to carry
    wr(8'hE9, 8'hF0);
    wr(8'hF9, 8'h12);
    wr(8'hDB, 8'h08);
    wr(8'hEB, 8'h05);
    wr(8'hFB, 8'h13);
    wr(8'hDC, 8'h0C);
    wr(8'hEC, 8'h00);
    wr(8'hFC, 8'h13);
    wr(8'hD8, 8'h40);
    repeat (40) @(posedge clk);
    chk("irq masked", 1'b0, irq_request);
    chk("toggle pins", 5'h1B, module_output_pin);
    rd(8'hD8, 8'h46);
    wr(8'hDB, 8'h49);
    repeat (3) @(posedge clk);
    chk("irq", 1'b1, irq_request);
    rd(8'hD8, 8'h46);
    wr(8'hD8, 8'h00);
    repeat (3) @(posedge clk);
    chk("irq cleared", 1'b0, irq_request);
    wr(8'hDB, 8'h00);
    wr(8'hDC, 8'h00);
    $display("test timer done");
    wr(8'hEA, 8'h40);
    wr(8'hFA, 8'hC0);
    wr(8'hDA, 8'h42);
    v = seed[7:0];
    seed = lfsr(seed);
    wr(8'hED, v);
    wr(8'hFD, v);
    wr(8'hDD, 8'h42);
    wr(8'hD8, 8'h40);
    repeat (300) @(posedge clk);
    hi0 = 0;
    hi3 = 0;
    meas <= 1'b1;
    repeat (256) @(posedge clk);
    meas <= 1'b0;
    chk("pwm0 high", 64, hi0);
    chk("pwm3 high", 256 - int'(v), hi3);
    wr(8'hD8, 8'h00);
    wr(8'hDA, 8'h00);
    wr(8'hDD, 8'h00);
    $display("test pwm done");
    wr(8'hDE, 8'h08);
    wr(8'hEE, 8'h20);
    wr(8'hFE, 8'h00);
    wr(8'hE9, 8'h00);
    wr(8'hF9, 8'h00);
    pulses = 0;
    wr(8'hD8, 8'h40);
    repeat (60) @(posedge clk);
    chk("disarmed", 0, pulses);
    rd(8'hD8, 8'h50);
    wr(8'hD8, 8'h00);
    wr(8'hE9, 8'h00);
    wr(8'hF9, 8'h00);
    wr(8'hD9, 8'h40);
    pulses = 0;
    wr(8'hD8, 8'h40);
    repeat (60) @(posedge clk);
    chk("armed", 1, pulses);
    chk("pin4", 1'b1, module_output_pin[4]);
    // Hold off an armed watchdog by moving the compare value ahead
    wr(8'hD8, 8'h00);
    wr(8'hE9, 8'h00);
    wr(8'hF9, 8'h00);
    pulses = 0;
    wr(8'hD8, 8'h40);
    wr(8'hEE, 8'h00);
    wr(8'hFE, 8'h40);
    repeat (60) @(posedge clk);
    chk("held off", 0, pulses);
    $display("test watchdog done");
    repeat (5) @(posedge clk);
    finish_test();
  end
endmodule

bind capw_top capw_top_sva chk_i (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .module_output_pin(module_output_pin), .irq_request(irq_request),
  .internal_reset_req(internal_reset_req));

`default_nettype wire
